// ==== btt_unit.sv ====
// breakpoint match, trigger and trace output unit
`timescale 1ns/1ps
`include "btt_consts.svh"
module btt_unit
	import btt_pkg::*;
#(
	parameter int NUM_PC = `BTT_NUM_PC
)(
	input wire logic sys_clk_i, // core clock, 125 MHz
	input wire logic rst_b_i, // sync reset, active low
	input wire btt_acc_s dbg_acc_i, // serial debug channel access
	input wire btt_acc_s sup_acc_i, // supervisor core access
	input wire btt_cpu_s cpu_i, // observed processor activity
	input wire logic halt_ack_i, // core resumed, clears halt
	output logic [31:0] rd_data_o, // read data for either port
	output logic rd_vld_o, // read data valid pulse
	output logic halt_o, // halt request level
	output logic dbg_irq_o, // debug interrupt pulse
	output logic [3:0] processor_status_bus_o, // status nibble
	output logic [3:0] trace_data_bus_o, // data nibble
	output logic trace_clock_output_o // trace clock
);
	typedef struct packed {
		logic [31:0] addr_hi;
		logic [31:0] addr_lo;
		logic [31:0] data;
		logic [31:0] data_mask;
		logic [NUM_PC-1:0][31:0] pc;
		logic [31:0] pc_mask;
		btt_cfg_s cfg;
		logic armed;
		logic halt;
		logic irq;
		logic [31:0] rdata;
		logic rvld;
		logic tclk;
		logic tick;
		logic [31:0] pend_word;
		logic [3:0] pend_kind;
		logic pend;
	} btt_st_s;
	btt_st_s q_r, q_nxt;

	// match results and serialiser hookup
	logic addr_hit, data_hit, pc_hit;
	logic [NUM_PC-1:0] pc_hits;
	logic [2:0] hits;
	logic lvl1, lvl2;
	logic ser_busy;
	logic [3:0] ser_pst, ser_dat;
	logic [3:0] idle_stat;
	btt_acc_s acc;

	// per-register masked PC compare
	genvar gi;
	generate
		for (gi = 0; gi < NUM_PC; gi++) begin : g_pc
			assign pc_hits[gi] = cpu_i.pc_vld &&
				(((cpu_i.pc ^ q_r.pc[gi]) & ~q_r.pc_mask) == 32'h0);
		end
	endgenerate

	// match terms
	always_comb begin
		addr_hit = cpu_i.addr_vld && (cpu_i.addr >= q_r.addr_lo) &&
			(cpu_i.addr <= q_r.addr_hi);
		data_hit = cpu_i.data_vld &&
			(((cpu_i.data ^ q_r.data) & ~q_r.data_mask) == 32'h0);
		pc_hit = |pc_hits;
		hits = {pc_hit, data_hit, addr_hit};
		lvl1 = q_r.cfg.enable && (q_r.cfg.lvl1_sel != 3'h0) &&
			((hits & q_r.cfg.lvl1_sel) == q_r.cfg.lvl1_sel);
		lvl2 = q_r.cfg.enable && (q_r.cfg.lvl2_sel != 3'h0) &&
			((hits & q_r.cfg.lvl2_sel) == q_r.cfg.lvl2_sel);
	end

	// debug channel wins when both ports access at once
	// two access ports
	assign acc = (dbg_acc_i.wr || dbg_acc_i.rd) ? dbg_acc_i : sup_acc_i;

	// idle status: a halted core outranks one that is executing
	assign idle_stat = q_r.halt ? `BTT_PST_HALT :
		(cpu_i.pc_vld ? `BTT_PST_EXEC : `BTT_PST_IDLE);

	// next state for registers, trigger and trace pacing
	always_comb begin
		logic fire;
		fire = 1'b0;
		q_nxt = q_r;
		q_nxt.rvld = 1'b0;
		q_nxt.irq = 1'b0;
		if (acc.wr) begin
			unique case (acc.sel)
				`BTT_SEL_ADDR_HI: q_nxt.addr_hi = acc.wdata;
				`BTT_SEL_ADDR_LO: q_nxt.addr_lo = acc.wdata;
				`BTT_SEL_DATA: q_nxt.data = acc.wdata;
				`BTT_SEL_DATA_MASK: q_nxt.data_mask = acc.wdata;
				`BTT_SEL_PC_MASK: q_nxt.pc_mask = acc.wdata;
				`BTT_SEL_CFG: begin
					// a new config drops any half-armed sequence, unless a level-1 match under the old config arms it in the same cycle
					q_nxt.cfg = btt_cfg_s'(acc.wdata);
					q_nxt.armed = 1'b0;
				end
				default: begin
					if (acc.sel >= `BTT_SEL_PC0 && acc.sel < `BTT_SEL_PC_MASK)
						q_nxt.pc[acc.sel[1:0]] = acc.wdata;
				end
			endcase
		end
		if (acc.rd) begin
			q_nxt.rvld = 1'b1;
			unique case (acc.sel)
				`BTT_SEL_ADDR_HI: q_nxt.rdata = q_r.addr_hi;
				`BTT_SEL_ADDR_LO: q_nxt.rdata = q_r.addr_lo;
				`BTT_SEL_DATA: q_nxt.rdata = q_r.data;
				`BTT_SEL_DATA_MASK: q_nxt.rdata = q_r.data_mask;
				`BTT_SEL_PC_MASK: q_nxt.rdata = q_r.pc_mask;
				// armed flag reads back as the shows-state bit 31
				`BTT_SEL_CFG: q_nxt.rdata = {q_r.armed, q_r.cfg[30:0]};
				default: begin
					if (acc.sel >= `BTT_SEL_PC0 && acc.sel < `BTT_SEL_PC_MASK)
						q_nxt.rdata = q_r.pc[acc.sel[1:0]];
					else
						q_nxt.rdata = 32'h0;
				end
			endcase
		end

		if (q_r.cfg.two_level) begin
			if (q_r.armed && lvl2) begin
				fire = 1'b1;
				q_nxt.armed = 1'b0;
			end else if (lvl1) begin
				q_nxt.armed = 1'b1;
			end
		end else begin
			fire = lvl1;
		end

		// halt or debug interrupt
		// a new trigger in the cycle of the clear wins, so no halt is lost
		if (halt_ack_i)
			q_nxt.halt = 1'b0;
		if (fire) begin
			if (q_r.cfg.halt_not_irq)
				q_nxt.halt = 1'b1;
			else
				q_nxt.irq = 1'b1;
		end

		// the serialiser steps as the trace clock falls, so the tool's
		// rising-edge sample always finds a nibble that has settled
		// trace clock at half rate
		q_nxt.tclk = ~q_r.tclk;
		q_nxt.tick = ~q_r.tclk;

		// one word waits at most behind the one shifting; later events drop rather than stall
		// queue branch target or operand
		if (q_r.pend && !ser_busy)
			q_nxt.pend = 1'b0;
		if (!q_nxt.pend) begin
			if (cpu_i.branch) begin
				q_nxt.pend = 1'b1;
				q_nxt.pend_word = cpu_i.target;
				q_nxt.pend_kind = `BTT_PST_BRANCH;
			end else if (cpu_i.data_vld) begin
				q_nxt.pend = 1'b1;
				q_nxt.pend_word = cpu_i.data;
				q_nxt.pend_kind = `BTT_PST_OPER;
			end
		end
	end

	// state register
	always_ff @(posedge sys_clk_i) begin
		if (!rst_b_i) begin
			q_r <= '0;
		end else begin
			q_r <= q_nxt;
		end
	end

	btt_trace u_trace (
		.sys_clk_i(sys_clk_i),
		.rst_b_i(rst_b_i),
		.tick_i(q_r.tick),
		.load_i(q_r.pend),
		.kind_i(q_r.pend_kind),
		.word_i(q_r.pend_word),
		.stat_i(idle_stat),
		.busy_o(ser_busy),
		.pst_o(ser_pst),
		.dat_o(ser_dat)
	);

	// every output is a register of this block or of the serialiser
	assign rd_data_o = q_r.rdata;
	assign rd_vld_o = q_r.rvld;
	assign halt_o = q_r.halt;
	assign dbg_irq_o = q_r.irq;
	assign processor_status_bus_o = ser_pst;
	assign trace_data_bus_o = ser_dat;
	assign trace_clock_output_o = q_r.tclk;
endmodule // btt_unit

// ==== btt_consts.svh ====
// constants for the breakpoint, trigger and trace unit
`ifndef BTT_CONSTS_SVH
`define BTT_CONSTS_SVH
`define BTT_NUM_PC 4
`define BTT_NUM_BKPT 9
`define BTT_SEL_ADDR_HI 4'h0
`define BTT_SEL_ADDR_LO 4'h1
`define BTT_SEL_DATA 4'h2
`define BTT_SEL_DATA_MASK 4'h3
`define BTT_SEL_PC0 4'h4
`define BTT_SEL_PC_MASK 4'h8
`define BTT_SEL_CFG 4'h9
`define BTT_CFG_RESET 32'h00000000
`define BTT_PST_IDLE 4'h0
`define BTT_PST_EXEC 4'h1
`define BTT_PST_OPER 4'h8
`define BTT_PST_BRANCH 4'h5
`define BTT_PST_HALT 4'hf
`define BTT_TRACE_DIV 2
`endif

// ==== btt_pkg.sv ====
// types for the breakpoint, trigger and trace unit
package btt_pkg;
	typedef enum logic [1:0] {
		BTT_TRC_IDLE,
		BTT_TRC_OPER,
		BTT_TRC_BRANCH
	} btt_trc_e;
	// trigger configuration word layout
	typedef struct packed {
		logic [21:0] rsvd;
		logic enable;
		logic halt_not_irq;
		logic two_level;
		logic [2:0] lvl2_sel;
		logic [2:0] lvl1_sel;
		logic pc_any;
	} btt_cfg_s;
	// register access from either the serial channel or supervisor core
	typedef struct packed {
		logic wr;
		logic rd;
		logic [3:0] sel;
		logic [31:0] wdata;
	} btt_acc_s;
	// processor activity observed for match and trace
	typedef struct packed {
		logic addr_vld;
		logic [31:0] addr;
		logic data_vld;
		logic [31:0] data;
		logic pc_vld;
		logic [31:0] pc;
		logic branch;
		logic [31:0] target;
	} btt_cpu_s;
endpackage

// ==== btt_trace.sv ====
// nibble serialiser for the trace buses at half core rate
`timescale 1ns/1ps
module btt_trace
	import btt_pkg::*;
(
	input wire logic sys_clk_i, // core clock
	input wire logic rst_b_i, // sync reset, active low
	input wire logic tick_i, // half-rate update enable
	input wire logic load_i, // new word to send
	input wire logic [3:0] kind_i, // status code for word
	input wire logic [31:0] word_i, // word to serialise
	input wire logic [3:0] stat_i, // status when idle
	output logic busy_o, // word still shifting
	output logic [3:0] pst_o, // status nibble
	output logic [3:0] dat_o // data nibble
);
	typedef struct packed {
		logic [31:0] sh;
		logic [3:0] cnt;
		logic [3:0] kind;
		logic [3:0] processor_status_bus;
		logic [3:0] dat;
	} btt_ser_s;
	btt_ser_s q_r, q_nxt;

	// low nibble first, eight nibbles per word
	always_comb begin
		q_nxt = q_r;
		if (load_i && q_r.cnt == 4'h0) begin
			q_nxt.sh = word_i;
			q_nxt.cnt = 4'h8;
			q_nxt.kind = kind_i;
		end else if (tick_i) begin
			if (q_r.cnt != 4'h0) begin
				q_nxt.processor_status_bus = q_r.kind;
				q_nxt.dat = q_r.sh[3:0];
				q_nxt.sh = {4'h0, q_r.sh[31:4]};
				q_nxt.cnt = q_r.cnt - 4'h1;
			end else begin
				q_nxt.processor_status_bus = stat_i;
				q_nxt.dat = 4'h0;
			end
		end
	end

	// state register
	always_ff @(posedge sys_clk_i) begin
		if (!rst_b_i) begin
			q_r <= '0;
		end else begin
			q_r <= q_nxt;
		end
	end

	assign busy_o = (q_r.cnt != 4'h0);
	assign pst_o = q_r.processor_status_bus;
	assign dat_o = q_r.dat;
endmodule // btt_trace

// ==== btt_unit_properties.sv ====
// port assertions for the breakpoint, trigger and trace unit
`timescale 1ns/1ps
module btt_unit_checker
	import btt_pkg::*;
#(
	parameter int NUM_PC = 4
)(
	input wire logic sys_clk_i, // core clock
	input wire logic rst_b_i, // sync reset
	input wire btt_acc_s dbg_acc_i, // serial access
	input wire btt_acc_s sup_acc_i, // core access
	input wire btt_cpu_s cpu_i, // activity
	input wire logic halt_ack_i, // halt clear
	input wire logic [31:0] rd_data_o, // read data
	input wire logic rd_vld_o, // read valid
	input wire logic halt_o, // halt level
	input wire logic dbg_irq_o, // irq pulse
	input wire logic [3:0] processor_status_bus_o, // status
	input wire logic [3:0] trace_data_bus_o, // data
	input wire logic trace_clock_output_o // trace clock
);
	default clocking @(posedge sys_clk_i); endclocking
	default disable iff (!rst_b_i);
	trace_clk_a: assert property (
		$past(rst_b_i) |-> trace_clock_output_o != $past(trace_clock_output_o))
		else $error("trace clock did not toggle");
	rd_pulse_a: assert property (
		$past(rst_b_i) |-> rd_vld_o ==
		$past(dbg_acc_i.rd || (!dbg_acc_i.wr && sup_acc_i.rd)))
		else $error("read valid wrong");
	unmapped_zero_a: assert property (
		$past(rst_b_i && dbg_acc_i.rd && dbg_acc_i.sel > 4'h9)
		|-> rd_data_o == 32'h0) else $error("unmapped read not zero");
	wr_rd_back_a: assert property (
		(dbg_acc_i.wr && dbg_acc_i.sel < 4'h9) ##1 (dbg_acc_i.rd &&
		dbg_acc_i.sel == $past(dbg_acc_i.sel)) |=>
		rd_data_o == $past(dbg_acc_i.wdata, 2)) else $error("readback wrong");
	halt_hold_a: assert property (
		halt_o && !halt_ack_i |=> halt_o) else $error("halt dropped");
	irq_excl_a: assert property (
		dbg_irq_o |-> !$rose(halt_o)) else $error("halt and irq together");
	nibble_hold_a: assert property (
		$changed({processor_status_bus_o, trace_data_bus_o}) |=>
		$stable({processor_status_bus_o, trace_data_bus_o}))
		else $error("trace nibble held one cycle");
	rd_hold_a: assert property (
		$changed(rd_data_o) |-> rd_vld_o) else $error("read data moved");
endmodule // btt_unit_checker
bind btt_unit btt_unit_checker #(.NUM_PC(NUM_PC)) chk_u (
	.sys_clk_i(sys_clk_i), .rst_b_i(rst_b_i), .dbg_acc_i(dbg_acc_i),
	.sup_acc_i(sup_acc_i), .cpu_i(cpu_i), .halt_ack_i(halt_ack_i),
	.rd_data_o(rd_data_o), .rd_vld_o(rd_vld_o), .halt_o(halt_o),
	.dbg_irq_o(dbg_irq_o), .processor_status_bus_o(processor_status_bus_o),
	.trace_data_bus_o(trace_data_bus_o),
	.trace_clock_output_o(trace_clock_output_o));

// ==== btt_trace_tool.sv ====
// debug tool model that captures trace words
`timescale 1ns/1ps
`include "btt_consts.svh"
module btt_trace_tool (
	input wire logic sys_clk_i, // edge finding clock
	input wire logic tclk_i, // trace clock
	input wire logic [3:0] pst_i, // status nibble
	input wire logic [3:0] dat_i, // data nibble
	output logic [31:0] word_o, // last word
	output logic [3:0] kind_o, // its status
	output int count_o // words seen
);
	logic tclk_q = 1'b0;
	int nib = 0;
	logic [31:0] sh = 32'h0;
	initial {word_o, kind_o, count_o} = '0;
	always @(posedge sys_clk_i) begin
		tclk_q <= tclk_i;
		if (tclk_i && !tclk_q &&
			(pst_i == `BTT_PST_BRANCH || pst_i == `BTT_PST_OPER)) begin
			sh <= {dat_i, sh[31:4]};
			if (nib == 7) begin
				word_o <= {dat_i, sh[31:4]};
				kind_o <= pst_i;
				count_o <= count_o + 1;
				nib <= 0;
			end else begin
				nib <= nib + 1;
			end
		end
	end
endmodule // btt_trace_tool

// ==== test_btt_unit.sv ====
// self-checking bench for the breakpoint, trigger and trace unit
`timescale 1ns/1ps
`include "btt_consts.svh"
`define CHK(n, e, g) begin num_checks++; if ((g) !== (e)) begin \
	num_errors++; $display("Error %s exp %h got %h", n, e, g); end end
module test_btt_unit;
	import btt_pkg::*;
	logic clk, rst_b, ack, vld, halt, irq, tclk;
	btt_acc_s dbg, sup;
	btt_cpu_s cpu;
	logic [31:0] rdat, tw;
	logic [3:0] processor_status_bus, dat, tk;
	int tn, num_errors = 0, num_checks = 0;
	btt_unit dut_u (.sys_clk_i(clk), .rst_b_i(rst_b), .dbg_acc_i(dbg),
		.sup_acc_i(sup), .cpu_i(cpu), .halt_ack_i(ack), .rd_data_o(rdat),
		.rd_vld_o(vld), .halt_o(halt), .dbg_irq_o(irq),
		.processor_status_bus_o(processor_status_bus), .trace_data_bus_o(dat),
		.trace_clock_output_o(tclk));
	btt_trace_tool tool_u (.sys_clk_i(clk), .tclk_i(tclk), .pst_i(processor_status_bus),
		.dat_i(dat), .word_o(tw), .kind_o(tk), .count_o(tn));
	// clock at 125 MHz
	initial begin
		clk = 1'b0;
		forever #4 clk = ~clk;
	end
	task automatic acc(bit p, logic w, logic r, logic [3:0] s, logic [31:0] d);
		@(posedge clk);
		if (p) dbg <= {w, r, s, d};
		else sup <= {w, r, s, d};
		@(posedge clk);
		dbg <= '0;
		sup <= '0;
	endtask
	task automatic rdchk(bit p, logic [3:0] s, logic [31:0] e);
		acc(p, 1'b0, 1'b1, s, 32'h0);
		#1;
		`CHK("rd_data", e, rdat)
		`CHK("rd_vld", 1'b1, vld)
	endtask
	// one cycle of activity, then settle past the answer edge
	task automatic go(btt_cpu_s c);
		@(posedge clk);
		cpu <= c;
		@(posedge clk);
		cpu <= '0;
		#1;
	endtask
	task automatic t_regs();
		for (int i = 0; i < 9; i++) acc(1, 1, 0, 4'(i), 32'ha5c30000 + i);
		for (int i = 0; i < 9; i++) rdchk(0, 4'(i), 32'ha5c30000 + i);
		acc(0, 1, 0, 4'hc, 32'hffffffff);
		rdchk(1, 4'hc, 32'h0);
		// both ports at once: the serial port must win
		@(posedge clk);
		dbg <= {2'b10, 4'h0, 32'h0000aaaa};
		sup <= {2'b10, 4'h0, 32'h00005555};
		@(posedge clk);
		dbg <= {2'b01, 4'h0, 32'h0};
		sup <= '0;
		@(posedge clk);
		dbg <= '0;
		#1;
		`CHK("arbiter", 32'h0000aaaa, rdat)
	endtask
	task automatic t_trace(btt_cpu_s c, logic [3:0] k, logic [31:0] w);
		int n0;
		n0 = tn;
		go(c);
		for (int i = 0; i < 80 && tn == n0; i++) @(posedge clk);
		`CHK("trace_kind", k, tk)
		`CHK("trace_word", w, tw)
	endtask
	task automatic t_halt();
		acc(1, 1, 0, 4'h4, 32'h00001230);
		acc(1, 1, 0, 4'h8, 32'h0000000f);
		acc(1, 1, 0, 4'h9, 32'h00000308);
		go('{pc_vld: 1'b1, pc: 32'h00001247, default: '0});
		`CHK("halt_miss", 1'b0, halt)
		go('{pc_vld: 1'b1, pc: 32'h00001237, default: '0});
		`CHK("halt_hit", 1'b1, halt)
		repeat (3) @(posedge clk);
		#1;
		`CHK("halt_hold", 1'b1, halt)
		`CHK("halt_status", `BTT_PST_HALT, processor_status_bus)
		@(posedge clk);
		ack <= 1'b1;
		@(posedge clk);
		ack <= 1'b0;
		#1;
		`CHK("halt_ack", 1'b0, halt)
	endtask
	task automatic t_irq();
		acc(1, 1, 0, 4'h1, 32'h00000100);
		acc(1, 1, 0, 4'h0, 32'h000001ff);
		acc(1, 1, 0, 4'h9, 32'h00000202);
		go('{addr_vld: 1'b1, addr: 32'h00000200, default: '0});
		`CHK("irq_out", 1'b0, irq)
		go('{addr_vld: 1'b1, addr: 32'h000001ff, default: '0});
		`CHK("irq_hi", 1'b1, irq)
		go('{addr_vld: 1'b1, addr: 32'h00000100, default: '0});
		`CHK("irq_lo", 1'b1, irq)
	endtask
	task automatic t_two();
		// supervisor port writes the data value
		acc(0, 1, 0, 4'h2, 32'hcafe0001);
		acc(1, 1, 0, 4'h3, 32'h0);
		acc(1, 1, 0, 4'h9, 32'h000002a2);
		go('{data_vld: 1'b1, data: 32'hcafe0001, default: '0});
		`CHK("lvl2_alone", 1'b0, irq)
		go('{addr_vld: 1'b1, addr: 32'h00000150, default: '0});
		`CHK("lvl1_arm", 1'b0, irq)
		rdchk(1, 4'h9, 32'h800002a2);
		go('{data_vld: 1'b1, data: 32'hcafe0001, default: '0});
		`CHK("lvl2_fire", 1'b1, irq)
		go('{data_vld: 1'b1, data: 32'hcafe0001, default: '0});
		`CHK("disarmed", 1'b0, irq)
	endtask
	task automatic tally_and_finish();
		$display("checks %0d errors %0d", num_checks, num_errors);
		if (num_errors == 0 && num_checks > 0) $display("Test passed");
		else $display("Test failed");
		$finish;
	endtask
	// main sequence after 16 cycles of reset
	initial begin
		{rst_b, ack, dbg, sup, cpu} = '0;
		repeat (16) @(posedge clk);
		rst_b <= 1'b1;
		t_regs();
		t_trace('{branch: 1'b1, target: 32'h87654321, default: '0},
			`BTT_PST_BRANCH, 32'h87654321);
		t_trace('{data_vld: 1'b1, data: 32'h0a0b0c0d, default: '0},
			`BTT_PST_OPER, 32'h0a0b0c0d);
		t_halt();
		t_irq();
		t_two();
		tally_and_finish();
	end
	// hang guard well past the expected run
	initial begin
		repeat (5000) @(posedge clk);
		num_errors++;
		tally_and_finish();
	end
endmodule // test_btt_unit
